// ==== tb/test_trt_timer.sv ====
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// Self-checking bench of the timer block
// ************************************************************
module test_trt_timer;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        ext_in = 1'b1;   // External clock pin, idles high
  logic [1:0]  htrans = 2'h0;
  logic [7:0]  haddr = 8'h00;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, timer_irq, event_irq;
  logic        rd_dp = 1'b0;    // Read data phase under way
  logic        irq_d = 1'b0;    // Last timer_irq level
  int          bad_count = 0;
  int          checks_done = 0;
  int          cyc = 0;         // Free cycle count
  int          last_hit = 0;    // Cycle of the last request rise
  logic [31:0] rd_q[$];         // Read data due, oldest first
  int          per_q[$];        // Cycles due between two hits
  logic [1:0]  pin_q[$];        // Levels due on {timer_irq, event_irq}
  logic [7:0]  p;
  logic [15:0] r;

  always #4 clk = ~clk;

  trt_timer i_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .timer_ext_input(ext_in), .timer_irq(timer_irq),
    .event_irq(event_irq));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic print_verdict;
    if (bad_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  // Watcher: compares each result against the oldest note of its kind
  always @(posedge clk) begin
    cyc <= cyc + 1;
    irq_d <= timer_irq;
    rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
    if (rd_dp && hreadyout) cmp(hrdata, rd_q.pop_front());
    if (pin_q.size() > 0) cmp({30'h0, timer_irq, event_irq}, {30'h0, pin_q.pop_front()});
    if (timer_irq && !irq_d) begin
      if (per_q.size() > 0) cmp(32'(cyc - last_hit), 32'(per_q.pop_front()));
      last_hit <= cyc;
    end
  end

  // One single word transfer; waits are bounded although the slave never stalls
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) begin bad_count++; print_verdict(); end
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask : rd

  // Pins are levels: let the last write settle before looking
  task automatic pins(input logic t, input logic e);
    repeat (3) @(posedge clk);
    pin_q.push_back({t, e});
  endtask : pins

  task automatic hit;
    int n;
    n = 0;
    while (timer_irq !== 1'b1 && n < 70000) begin @(posedge clk); n++; end
    if (n >= 70000) begin bad_count++; print_verdict(); end
  endtask : hit

  // Stop, program, then time two hits apart; the first hit only aligns the phase
  task automatic period(input logic [15:0] m, input logic [15:0] rv, input int exp);
    wr(trt_pkg::MODE_OFS, 32'h0);
    wr(trt_pkg::REF_OFS, {16'h0, rv});
    wr(trt_pkg::MODE_OFS, {16'h0, m});
    hit();
    wr(trt_pkg::EVENT_OFS, 32'h2);
    per_q.push_back(exp);
    repeat (2) @(posedge clk);
    hit();
  endtask : period

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    void'($urandom(85702));
    rd(trt_pkg::MODE_OFS, 32'h0);
    rd(trt_pkg::REF_OFS, 32'hffff);
    rd(trt_pkg::COUNT_OFS, 32'h0);
    rd(trt_pkg::CAPT_OFS, 32'h0);
    rd(8'h40, 32'h0);
    p = 8'($urandom_range(7));
    r = 16'($urandom_range(7, 1));
    wr(trt_pkg::MODE_OFS, {16'h0, p, 8'h00});
    rd(trt_pkg::MODE_OFS, {16'h0, p, 8'h00});
    period(16'hff1b, 16'h0001, 512);
    period({p, 8'h1d}, r, 16 * (p + 1) * (r + 1));
    period(16'h001b, 16'h001f, 32);
    wr(trt_pkg::IRQ_CLR_OFS, 32'h3);
    wr(trt_pkg::IRQ_EN_OFS, 32'h1);
    period(16'h0013, 16'h0004, 65536);
    wr(trt_pkg::MODE_OFS, 32'h0011);
    rd(trt_pkg::IRQ_STAT_OFS, 32'h3);
    pins(1'b1, 1'b1);
    wr(trt_pkg::IRQ_EN_OFS, 32'h0);
    pins(1'b1, 1'b0);
    wr(trt_pkg::IRQ_EN_OFS, 32'h2);
    pins(1'b1, 1'b1);
    wr(trt_pkg::IRQ_CLR_OFS, 32'h3);
    wr(trt_pkg::IRQ_STAT_OFS, 32'h3);
    rd(trt_pkg::IRQ_STAT_OFS, 32'h0);
    wr(trt_pkg::EVENT_OFS, 32'h0);
    rd(trt_pkg::EVENT_OFS, 32'h2);
    pins(1'b1, 1'b0);
    wr(trt_pkg::MODE_OFS, 32'h0001);
    pins(1'b0, 1'b0);
    wr(trt_pkg::EVENT_OFS, 32'h2);
    rd(trt_pkg::EVENT_OFS, 32'h0);
    // Flag must still set with its request masked
    wr(trt_pkg::IRQ_EN_OFS, 32'h0);
    wr(trt_pkg::MODE_OFS, 32'h0);
    wr(trt_pkg::REF_OFS, 32'h3);
    wr(trt_pkg::MODE_OFS, 32'h000b);
    pins(1'b0, 1'b0);
    rd(trt_pkg::EVENT_OFS, 32'h2);
    wr(trt_pkg::MODE_OFS, 32'h0);
    repeat (20) @(posedge clk);
    rd(trt_pkg::EVENT_OFS, 32'h0);
    rd(trt_pkg::COUNT_OFS, 32'h0);
    wr(trt_pkg::MODE_OFS, 32'h0001);
    repeat (20) @(posedge clk);
    rd(trt_pkg::COUNT_OFS, 32'h0);
    // External pin, prescale two: six falling edges make three counts
    wr(trt_pkg::MODE_OFS, 32'h0107);
    repeat (6) begin
      ext_in <= 1'b0;
      repeat (4) @(posedge clk);
      ext_in <= 1'b1;
      repeat (4) @(posedge clk);
    end
    repeat (6) @(posedge clk);
    rd(trt_pkg::COUNT_OFS, 32'h3);
    wr(trt_pkg::COUNT_OFS, $urandom);
    rd(trt_pkg::COUNT_OFS, 32'h0);
    repeat (4) @(posedge clk);
    print_verdict();
  end
endmodule : test_trt_timer
`default_nettype wire

// ==== tb/trt_timer_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// Port-level checks of the timer block
// ************************************************************
module trt_timer_asserts #(
  parameter int PS_W = 8                  // Prescaler width, handed on by the bind
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  input  wire logic [31:0] hrdata,
  input  wire logic        hreadyout,
  input  wire logic        hresp,
  input  wire logic        timer_ext_input,
  input  wire logic        timer_irq,
  input  wire logic        event_irq
);
  logic        ap;      // Address phase accepted
  logic        wr_dp;   // Write data phase under way
  logic        rd_dp;   // Read data phase under way
  logic        reg_q;   // Read of mode or reference
  logic        zero_q;  // Read of capture or of an unmapped word
  logic [7:0]  a_q;     // Address of the data phase
  logic [15:0] mode_s;  // Shadow of mode_control_reg
  logic [15:0] ref_s;   // Shadow of reference_value_reg
  logic [1:0]  en_s;    // Shadow of the interrupt enable bits
  logic [31:0] exp_q;   // Read data due, frozen at address phase
  logic [1:0]  stop_n;  // Cycles with run low, saturating at three
  assign ap = hsel && hready && htrans[1];

  // Track settings; a read sees the value of its address phase, not a later write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {wr_dp, rd_dp, reg_q, zero_q, a_q, en_s, stop_n, exp_q} <= '0;
      mode_s <= trt_pkg::MODE_RST;
      ref_s  <= trt_pkg::REF_RST;
    end else begin
      wr_dp  <= ap && hwrite;
      rd_dp  <= ap && !hwrite;
      a_q    <= haddr;
      reg_q  <= haddr == trt_pkg::MODE_OFS || haddr == trt_pkg::REF_OFS;
      zero_q <= haddr == trt_pkg::CAPT_OFS || haddr > 8'h1f;
      exp_q  <= {16'h0000, (haddr == trt_pkg::MODE_OFS) ? mode_s : ref_s};
      stop_n <= mode_s[trt_pkg::MODE_RUN_BIT] ? 2'h0 : stop_n + {1'b0, stop_n != 2'h3};
      if (wr_dp && a_q == trt_pkg::MODE_OFS) mode_s <= hwdata[15:0];
      if (wr_dp && a_q == trt_pkg::REF_OFS) ref_s <= hwdata[15:0];
      if (wr_dp && a_q == trt_pkg::IRQ_EN_OFS) en_s <= hwdata[1:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_bus_okay; hreadyout && !hresp; endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus answer not ready or not okay");
  property p_rd_regs; rd_dp && reg_q |-> hrdata == exp_q; endproperty
  a_rd_regs: assert property (p_rd_regs) else $error("mode or reference read wrong");
  property p_rd_zero; rd_dp && zero_q |-> hrdata == 32'h0; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("empty word read not zero");
  property p_irq_gate; timer_irq |-> $past(mode_s[trt_pkg::MODE_REFIRQ_BIT]); endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("request without enable");
  // A request may only drop after software touched a register; a falling run
  // enable clears the flag one cycle late, so the drop may trail the write by two
  property p_irq_hold;
    timer_irq && !wr_dp && !$past(wr_dp) && !$past(wr_dp, 2) |=> timer_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("request dropped alone");
  property p_stop_quiet; stop_n == 2'h3 |-> !timer_irq; endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("request while stopped");
  property p_ev_gate; event_irq |-> $past(en_s) != 2'h0; endproperty
  a_ev_gate: assert property (p_ev_gate) else $error("status interrupt without enable");
  property p_ev_hold; event_irq && !wr_dp && !$past(wr_dp) |=> event_irq; endproperty
  a_ev_hold: assert property (p_ev_hold) else $error("status interrupt dropped alone");
endmodule : trt_timer_asserts

bind trt_timer trt_timer_asserts #(.PS_W(PS_W)) i_asserts (
  .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .timer_ext_input(timer_ext_input), .timer_irq(timer_irq),
  .event_irq(event_irq));
`default_nettype wire

// ==== verilog/trt_pkg.sv ====
// ************************************************************
// Register map and field layout
// ************************************************************
package trt_pkg;

  // Word offsets on the register bus (byte addresses)
  localparam logic [7:0] MODE_OFS     = 8'h00;  // mode_control_reg
  localparam logic [7:0] REF_OFS      = 8'h04;  // reference_value_reg
  localparam logic [7:0] CAPT_OFS     = 8'h08;  // capture value, reads zero here
  localparam logic [7:0] COUNT_OFS    = 8'h0c;  // count_value_reg
  localparam logic [7:0] EVENT_OFS    = 8'h10;  // event flags, write one to clear
  localparam logic [7:0] IRQ_STAT_OFS = 8'h14;  // sticky interrupt status, read only
  localparam logic [7:0] IRQ_CLR_OFS  = 8'h18;  // interrupt status clear, write only
  localparam logic [7:0] IRQ_EN_OFS   = 8'h1c;  // interrupt status enable

  // Mode control field positions
  localparam int MODE_RUN_BIT     = 0;   // Timer run enable
  localparam int MODE_CLK_LSB     = 1;   // Clock source select [2:1]
  localparam int MODE_RESTART_BIT = 3;   // restart_on_match
  localparam int MODE_REFIRQ_BIT  = 4;   // reference_irq_enable
  localparam int MODE_PS_LSB      = 8;   // Prescale [15:8]

  // Event flag positions
  localparam int EV_CAP_BIT = 0;         // capture_event_flag
  localparam int EV_REF_BIT = 1;         // Reference event flag

  // Clock source encodings
  localparam logic [1:0] CLK_STOP = 2'h0;
  localparam logic [1:0] CLK_DIV1 = 2'h1;
  localparam logic [1:0] CLK_DIV16 = 2'h2;
  localparam logic [1:0] CLK_EXT  = 2'h3;

  // Reset values
  localparam logic [15:0] MODE_RST  = 16'h0000;
  localparam logic [15:0] REF_RST   = 16'hffff;
  localparam logic [15:0] COUNT_RST = 16'h0000;

  // Fixed source divider for the divided bus clock
  localparam int SRC_DIV = 16;

endpackage : trt_pkg

// ==== verilog/trt_timer.sv ====
`timescale 1ns/10ps
`default_nettype none

module trt_timer #(
  parameter int PS_W = 8       // Prescaler width
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Pins and interrupts
  input  wire logic        timer_ext_input,
  output logic             timer_irq,
  output logic             event_irq
);

  // ************************************************************
  // Bus address phase capture
  // ************************************************************
  logic       wr_pend_r;     // Write data phase pending
  logic       rd_pend_r;     // Read data phase pending
  logic [7:0] addr_r;        // Latched address
  logic       addr_ok;       // Address phase is a real transfer

  assign addr_ok = hsel && hready && htrans[1];

  // Latch address phase; slave never stalls, so data phase takes one cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r    <= 8'h00;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      rd_pend_r <= addr_ok && !hwrite;
      if (addr_ok) begin
        addr_r <= haddr;
      end
    end
  end

  logic wr_mode, wr_ref, wr_count, wr_event, wr_iclr, wr_ien;  // Write strobes in data phase
  assign wr_mode  = wr_pend_r && (addr_r == trt_pkg::MODE_OFS);
  assign wr_ref   = wr_pend_r && (addr_r == trt_pkg::REF_OFS);
  assign wr_count = wr_pend_r && (addr_r == trt_pkg::COUNT_OFS);
  assign wr_event = wr_pend_r && (addr_r == trt_pkg::EVENT_OFS);
  assign wr_iclr  = wr_pend_r && (addr_r == trt_pkg::IRQ_CLR_OFS);
  assign wr_ien   = wr_pend_r && (addr_r == trt_pkg::IRQ_EN_OFS);

  // ************************************************************
  // Registers written by software
  // ************************************************************
  logic [15:0] mode_control_reg_r;    // Mode control
  logic [15:0] reference_value_reg_r; // Reference compare value
  logic [1:0]  irq_en_r;              // Interrupt status enables

  // Mode and reference hold their values across a software reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_control_reg_r    <= trt_pkg::MODE_RST;
      reference_value_reg_r <= trt_pkg::REF_RST;
      irq_en_r              <= 2'h0;
    end else begin
      if (wr_mode) begin
        mode_control_reg_r <= hwdata[15:0];
      end
      if (wr_ref) begin
        reference_value_reg_r <= hwdata[15:0];
      end
      if (wr_ien) begin
        irq_en_r <= hwdata[1:0];
      end
    end
  end

  logic             run_en;     // Timer run enable
  logic [1:0]       clk_sel;    // Clock source select
  logic             restart_on_match;
  logic             reference_irq_enable;
  logic [PS_W-1:0]  ps_set;     // Prescale setting
  assign run_en               = mode_control_reg_r[trt_pkg::MODE_RUN_BIT];
  assign clk_sel              = mode_control_reg_r[trt_pkg::MODE_CLK_LSB +: 2];
  assign restart_on_match     = mode_control_reg_r[trt_pkg::MODE_RESTART_BIT];
  assign reference_irq_enable = mode_control_reg_r[trt_pkg::MODE_REFIRQ_BIT];
  assign ps_set               = mode_control_reg_r[trt_pkg::MODE_PS_LSB +: PS_W];

  // ************************************************************
  // Software reset on falling run enable
  // ************************************************************
  logic run_q_r;   // Run enable one cycle ago
  logic sw_rst;    // One-cycle timer reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q_r <= 1'b0;
    end else begin
      run_q_r <= run_en;
    end
  end
  assign sw_rst = run_q_r && !run_en;

  // ************************************************************
  // External input synchroniser and falling-edge detect
  // ************************************************************
  logic [2:0] ext_sync_r;   // Three-stage synchroniser
  logic       ext_level_r;  // Filtered level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_sync_r  <= 3'h7;
      ext_level_r <= 1'b1;
    end else begin
      ext_sync_r <= {ext_sync_r[1:0], timer_ext_input};
      // Change counts only once stages two and three agree
      if (ext_sync_r[1] == ext_sync_r[2]) begin
        ext_level_r <= ext_sync_r[2];
      end
    end
  end
  logic ext_fall;  // Falling edge of the filtered level
  assign ext_fall = ext_level_r && (ext_sync_r[1] == ext_sync_r[2]) && !ext_sync_r[2];

  // ************************************************************
  // Divide-by-16 tick source
  // ************************************************************
  localparam int D16_W = $clog2(trt_pkg::SRC_DIV);
  localparam logic [D16_W-1:0] D16_LAST = D16_W'(trt_pkg::SRC_DIV - 1);
  logic [D16_W-1:0] div16_r;  // Free-running while enabled
  logic             div16_tick;
  // Runs from the bus clock, so the first divided tick may come early
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div16_r <= '0;
    end else if (!run_en || sw_rst) begin
      div16_r <= '0;
    end else if (div16_r == D16_LAST) begin
      div16_r <= '0;
    end else begin
      div16_r <= div16_r + 1'b1;
    end
  end
  assign div16_tick = run_en && (div16_r == D16_LAST);

  // Selected prescaler input tick
  logic src_tick;
  always_comb begin
    unique case (clk_sel)
      trt_pkg::CLK_STOP:  src_tick = 1'b0;
      trt_pkg::CLK_DIV1:  src_tick = 1'b1;
      trt_pkg::CLK_DIV16: src_tick = div16_tick;
      trt_pkg::CLK_EXT:   src_tick = ext_fall;
    endcase
  end

  // ************************************************************
  // Prescaler
  // ************************************************************
  logic [PS_W-1:0] ps_cnt_r;  // Prescale count
  logic            cnt_tick;  // One count advance
  assign cnt_tick = run_en && src_tick && (ps_cnt_r == ps_set);

  // Counter write or software reset restarts the prescaler
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ps_cnt_r <= '0;
    end else if (sw_rst || wr_count) begin
      ps_cnt_r <= '0;
    end else if (run_en && src_tick) begin
      ps_cnt_r <= (ps_cnt_r >= ps_set) ? '0 : ps_cnt_r + 1'b1;
    end
  end

  // ************************************************************
  // Counter and reference compare
  // ************************************************************
  logic [15:0] count_value_reg_r;  // 16-bit up-counter
  logic        match;              // Count equals reference
  assign match = (count_value_reg_r == reference_value_reg_r);

  // Reference hit is judged on the count a tick would leave behind
  logic        ref_hit;
  assign ref_hit = cnt_tick && (count_value_reg_r + 16'h0001 == reference_value_reg_r);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_value_reg_r <= trt_pkg::COUNT_RST;
    end else if (sw_rst || wr_count) begin
      count_value_reg_r <= trt_pkg::COUNT_RST;
    end else if (cnt_tick) begin
      if (restart_on_match && match) begin
        count_value_reg_r <= 16'h0000;
      end else begin
        count_value_reg_r <= count_value_reg_r + 16'h0001;
      end
    end
  end

  // ************************************************************
  // Event flags
  // ************************************************************
  logic ref_flag_r;                   // Reference event flag
  logic capture_event_flag_r;         // Capture flag, never set here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_flag_r           <= 1'b0;
      capture_event_flag_r <= 1'b0;
    end else if (sw_rst) begin
      ref_flag_r           <= 1'b0;
      capture_event_flag_r <= 1'b0;
    end else begin
      // Set wins over a clear in the same cycle
      if (ref_hit) begin
        ref_flag_r <= 1'b1;
      end else if (wr_event && hwdata[trt_pkg::EV_REF_BIT]) begin
        ref_flag_r <= 1'b0;
      end
      if (wr_event && hwdata[trt_pkg::EV_CAP_BIT]) begin
        capture_event_flag_r <= 1'b0;
      end
    end
  end

  // Request to the interrupt controller, held while the capture flag, or the reference flag with reference_irq_enable, is set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= (ref_flag_r && reference_irq_enable) || capture_event_flag_r;
    end
  end

  // ************************************************************
  // Sticky interrupt status
  // ************************************************************
  logic [1:0] irq_stat_r;  // Bit1 reference hit, bit0 counter wrap
  logic       wrap_hit;
  assign wrap_hit = cnt_tick && (count_value_reg_r == 16'hffff);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r <= 2'h0;
    end else begin
      // New events override a clear in the same cycle
      irq_stat_r <= (irq_stat_r & ~(wr_iclr ? hwdata[1:0] : 2'h0)) | {ref_hit, wrap_hit};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      event_irq <= 1'b0;
    end else begin
      event_irq <= |(irq_stat_r & irq_en_r);
    end
  end

  // ************************************************************
  // Read data and response
  // ************************************************************
  logic [31:0] rd_nxt;
  always_comb begin
    unique case (haddr)
      trt_pkg::MODE_OFS:     rd_nxt = {16'h0000, mode_control_reg_r};
      trt_pkg::REF_OFS:      rd_nxt = {16'h0000, reference_value_reg_r};
      trt_pkg::COUNT_OFS:    rd_nxt = {16'h0000, count_value_reg_r};
      trt_pkg::EVENT_OFS:    rd_nxt = {30'h0, ref_flag_r, capture_event_flag_r};
      trt_pkg::IRQ_STAT_OFS: rd_nxt = {30'h0, irq_stat_r};
      trt_pkg::IRQ_EN_OFS:   rd_nxt = {30'h0, irq_en_r};
      default:               rd_nxt = 32'h0000_0000;  // Unmapped reads zero
    endcase
  end

  // Read data registered at the address phase, valid through data phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= rd_nxt;
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule : trt_timer

`default_nettype wire
